// ==== include/usart_pkg.sv ====
/*
 * Shared constants of the serial unit control/status block: register offsets,
 * field positions, reset values and the link state encoding.
 * Assumes a 32-bit APB with word-aligned registers and one 10 MHz clock.
 */
package usart_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CSR = 8'h00;   // control_status_reg
    localparam logic [7:0] OFF_UCR = 8'h04;   // async_control_reg
    localparam logic [7:0] OFF_GCR = 8'h08;   // generic_control_reg
    localparam logic [7:0] OFF_DBUF = 8'h0C;  // shared_data_buffer
    localparam logic [7:0] OFF_BAUD = 8'h10;  // rate_mantissa_reg
    localparam logic [7:0] OFF_ISTAT = 8'h14; // Sticky event flags, write one to clear
    localparam logic [7:0] OFF_IMASK = 8'h18; // Event interrupt enables

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CSR_MODE = 7;
    localparam int CSR_RE = 6;
    localparam int CSR_SLAVE = 5;
    localparam int CSR_FE = 4;
    localparam int CSR_ERR = 3;
    localparam int CSR_RXB = 2;
    localparam int CSR_TXB = 1;
    localparam int UCR_FLUSH = 7;
    localparam int EV_RX = 0;
    localparam int EV_TX = 1;
    localparam int EV_NUM = 2;

    // ----------------------------------------------------------------
    // Reset values and timing
    // ----------------------------------------------------------------
    localparam logic [7:1] CSR_RST = 7'h00;
    localparam logic [6:0] UCR_RST = 7'h02;   // High stop bit level
    localparam logic [7:0] GCR_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam int GUARD_CYCLES_DEF = 16;     // One bit period after a flush

    // Link activity states, one-hot
    typedef enum logic [2:0] {
        LS_IDLE = 3'b001,
        LS_BUSY = 3'b010,
        LS_FLUSH = 3'b100
    } link_state_e;

endpackage : usart_pkg

// ==== verilog/flush_guard.sv ====
/*
 * Holds a flush for a fixed number of cycles and then reports done.
 * Assumes start_i is a one-cycle pulse; a new start restarts the count.
 */
module flush_guard #(
    parameter int CYCLES = 16
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Control
    input wire logic start_i,
    output logic done_o
);
    // The count register is 16 bits wide
    if (CYCLES < 1 || CYCLES > 65535) begin : g_bad
        $error("flush_guard: CYCLES must be 1 to 65535");
    end

    typedef struct packed {
        logic [15:0] cnt;
        logic done;
    } guard_s;

    guard_s q_r, q_nxt;

    // Count down from the load value, pulse done on the last step
    always_comb begin
        q_nxt = q_r;
        q_nxt.done = (q_r.cnt == 16'h0001) && !start_i;
        if (start_i) begin
            q_nxt.cnt = 16'(CYCLES);
        end else if (q_r.cnt != 16'h0000) begin
            q_nxt.cnt = q_r.cnt - 16'h0001;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign done_o = q_r.done;

endmodule : flush_guard

// ==== verilog/event_flags.sv ====
/*
 * Sticky event flags with write-one-to-clear and a masked level interrupt.
 * Assumes set_i and clr_i are single-cycle strobes; set wins over clear.
 */
module event_flags #(
    parameter int N = 2
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Events and software
    input wire logic [N-1:0] set_i,
    input wire logic [N-1:0] clr_i,
    input wire logic [N-1:0] mask_i,
    // Results
    output logic [N-1:0] flag_o,
    output logic irq_o
);
    if (N < 1) begin : g_bad
        $error("event_flags: N must be at least 1");
    end

    typedef struct packed {
        logic [N-1:0] flag;
        logic irq;
    } flags_s;

    flags_s q_r, q_nxt;
    logic [N-1:0] flag_nxt;

    // Per-flag update, a set in the clearing cycle is kept
    for (genvar i = 0; i < N; i++) begin : g_flag
        assign flag_nxt[i] = set_i[i] | (q_r.flag[i] & ~clr_i[i]);
    end

    // Interrupt raised only for enabled flags
    always_comb begin
        q_nxt.flag = flag_nxt;
        q_nxt.irq = |(flag_nxt & mask_i); // RQ4
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign flag_o = q_r.flag;
    assign irq_o = q_r.irq;

endmodule : event_flags

// ==== verilog/usart_status_flush_events.sv ====
/*
 * Control and status block of a dual-mode serial unit: mode and role bits,
 * error and byte flags, busy state, flush, completion events, DMA triggers.
 * Assumes an APB master on one side and a bit-level serial core on the other
 * that reports transfer start/end, receive and transmit completion as pulses.
 */
// Behaviour
// RQ1 - Writing one to flush stops the current operation and empties all data buffers.
// RQ2 - Software aligns a flush to an event or waits one bit period afterwards.
// RQ3 - Two event sources per unit: receive complete and transmit complete flags.
// RQ4 - A completion event raises the interrupt only when its enable is one.
// RQ5 - Two DMA trigger pulses, from the same events as the interrupt flags.
// RQ6 - The shared data buffer serves DMA as source or destination.
// RQ7 - Software must not use DMA while the sample phase select is one.
// RQ8 - Status bit 7 selects mode: zero synchronous, one asynchronous.
// RQ9 - Status bit 6 enables the asynchronous receiver when one.
// RQ10 - Status bit 5 selects role: zero master, one slave.
// RQ11 - Status bit 4 flags a received stop bit at the wrong level.
// RQ12 - Receive flags rise on first good stop bit; bad second stop flags later.
// RQ13 - Status bit 3 flags a parity failure.
// RQ14 - Status bit 2 reads one while a received byte is ready.
// RQ15 - Status bit 1 reads one once the last written byte was transmitted.
// RQ16 - Status bit 0 is read-only and shows busy.
// RQ17 - Flush is async control bit 7, reads zero, returns unit to idle.
// RQ18 - Synchronous master: busy follows the transfer, then transmitted bit is set.
// RQ19 - Flush drops busy next cycle and leaves error and byte flags unchanged.
module usart_status_flush_events
    import usart_pkg::*;
#(
    parameter int GUARD_CYCLES = GUARD_CYCLES_DEF
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Serial core events
    input wire logic xfer_start_i,
    input wire logic xfer_end_i,
    input wire logic rx_byte_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_frame_err_i,
    input wire logic rx_parity_err_i,
    input wire logic tx_done_i,
    // Configuration to the serial core
    output logic mode_async_o,
    output logic rx_enable_bit_o,
    output logic slave_role_o,
    output logic [6:0] async_cfg_o,
    output logic [7:0] generic_cfg_o,
    output logic [7:0] rate_mantissa_o,
    output logic [7:0] tx_data_o,
    output logic tx_load_o,
    output logic flush_o,
    // Events to processor and DMA
    output logic rx_done_irq_flag_o,
    output logic tx_done_irq_flag_o,
    output logic rx_done_dma_trigger_o,
    output logic tx_done_dma_trigger_o,
    output logic irq_o
);
    if (GUARD_CYCLES < 1) begin : g_bad
        $error("GUARD_CYCLES must be at least 1");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        link_state_e st;
        logic [7:1] csr;
        logic [6:0] ucr;
        logic [7:0] gcr;
        logic [7:0] baud;
        logic [7:0] txbuf;
        logic [7:0] rxbuf;
        logic [1:0] mask;
        logic [31:0] rdata;
        logic rdy;
        logic serr;
        logic load;
        logic flush;
        logic dma_rx;
        logic dma_tx;
    } top_s;

    top_s q_r, q_nxt;
    logic acc;
    logic wr;
    logic flush_req;
    logic flushing;
    logic rx_ok;
    logic rx_evt;
    logic tx_evt;
    logic guard_done;
    logic active;
    logic [1:0] ev_set;
    logic [1:0] ev_clr;
    logic [1:0] ev_flag;
    logic [31:0] rd_val;
    logic rd_bad;

    // ----------------------------------------------------------------
    // Bus access and event qualification
    // ----------------------------------------------------------------
    // Access completes in the second access-phase cycle
    assign acc = psel_i && penable_i && q_r.rdy;
    assign wr = acc && pwrite_i;
    assign flush_req = wr && (paddr_i == OFF_UCR) && pwdata_i[UCR_FLUSH]; // RQ17
    assign flushing = (q_r.st == LS_FLUSH) || flush_req;
    assign active = (q_r.st == LS_BUSY);

    // Receiver gated in asynchronous mode by its enable
    assign rx_ok = !flushing && (!q_r.csr[CSR_MODE] || q_r.csr[CSR_RE]); // RQ9
    assign rx_evt = rx_byte_i && rx_ok;
    assign tx_evt = tx_done_i && !flushing;

    // Two event sources per unit
    assign ev_set = {tx_evt, rx_evt}; // RQ3
    assign ev_clr = (wr && paddr_i == OFF_ISTAT) ? pwdata_i[1:0] : 2'h0;

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_bad = 1'b0;
        case (paddr_i)
            OFF_CSR: rd_val = {24'h00_0000, q_r.csr, active}; // RQ16
            OFF_UCR: rd_val = {24'h00_0000, 1'b0, q_r.ucr};   // RQ17
            OFF_GCR: rd_val = {24'h00_0000, q_r.gcr};
            OFF_DBUF: rd_val = {24'h00_0000, q_r.rxbuf};      // RQ6
            OFF_BAUD: rd_val = {24'h00_0000, q_r.baud};
            OFF_ISTAT: rd_val = {30'h0000_0000, ev_flag};
            OFF_IMASK: rd_val = {30'h0000_0000, q_r.mask};
            default: rd_bad = 1'b1;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        q_nxt.load = 1'b0;
        q_nxt.dma_rx = rx_evt; // RQ5
        q_nxt.dma_tx = tx_evt; // RQ5

        // APB: one wait state, then the answer
        q_nxt.rdy = psel_i && penable_i && !q_r.rdy;
        if (psel_i && penable_i && !q_r.rdy) begin
            q_nxt.rdata = pwrite_i ? 32'h0000_0000 : rd_val;
            q_nxt.serr = rd_bad;
        end else begin
            q_nxt.serr = 1'b0;
        end

        // Register writes
        if (wr) begin
            case (paddr_i)
                OFF_CSR: q_nxt.csr = pwdata_i[7:1]; // RQ8 RQ10
                OFF_UCR: q_nxt.ucr = pwdata_i[6:0];
                OFF_GCR: q_nxt.gcr = pwdata_i[7:0];
                OFF_DBUF: begin
                    q_nxt.txbuf = pwdata_i[7:0]; // RQ6
                    q_nxt.load = !flush_req;
                    q_nxt.csr[CSR_TXB] = 1'b0;
                end
                OFF_BAUD: q_nxt.baud = pwdata_i[7:0];
                OFF_IMASK: q_nxt.mask = pwdata_i[1:0];
                default: q_nxt.mask = q_r.mask;
            endcase
        end

        // Hardware sets win over software writes
        if (rx_frame_err_i && rx_ok) begin
            q_nxt.csr[CSR_FE] = 1'b1; // RQ11 RQ12
        end
        if (rx_parity_err_i && rx_ok) begin
            q_nxt.csr[CSR_ERR] = 1'b1; // RQ13
        end
        if (rx_evt) begin
            q_nxt.csr[CSR_RXB] = 1'b1; // RQ12 RQ14
            q_nxt.rxbuf = rx_data_i;
        end
        if (tx_evt) begin
            q_nxt.csr[CSR_TXB] = 1'b1; // RQ15
        end

        // Link activity
        case (q_r.st)
            LS_IDLE: begin
                if (flush_req) begin
                    q_nxt.st = LS_FLUSH;
                end else if (xfer_start_i) begin
                    q_nxt.st = LS_BUSY; // RQ16 RQ18
                end
            end
            LS_BUSY: begin
                if (flush_req) begin
                    q_nxt.st = LS_FLUSH; // RQ19
                end else if (xfer_end_i) begin
                    q_nxt.st = LS_IDLE; // RQ18
                    if (!q_r.csr[CSR_MODE] && !q_r.csr[CSR_SLAVE]) begin
                        q_nxt.csr[CSR_TXB] = 1'b1; // RQ18
                    end
                end
            end
            LS_FLUSH: begin
                // Held one bit period so the core settles before reuse
                if (guard_done && !flush_req) begin
                    q_nxt.st = LS_IDLE; // RQ2
                end
            end
            default: q_nxt.st = LS_IDLE;
        endcase

        // Flush empties both data buffers, flags are kept
        if (flush_req) begin
            q_nxt.txbuf = 8'h00; // RQ1
            q_nxt.rxbuf = 8'h00; // RQ1
        end
        q_nxt.flush = (q_nxt.st == LS_FLUSH); // RQ1
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q_r.st <= LS_IDLE;
            q_r.csr <= CSR_RST;
            q_r.ucr <= UCR_RST;
            q_r.gcr <= GCR_RST;
            q_r.baud <= BAUD_RST;
            q_r.txbuf <= 8'h00;
            q_r.rxbuf <= 8'h00;
            q_r.mask <= MASK_RST;
            q_r.rdata <= 32'h0000_0000;
            q_r.rdy <= 1'b0;
            q_r.serr <= 1'b0;
            q_r.load <= 1'b0;
            q_r.flush <= 1'b0;
            q_r.dma_rx <= 1'b0;
            q_r.dma_tx <= 1'b0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    // Bit-period hold after a flush
    flush_guard #(
        .CYCLES(GUARD_CYCLES)
    ) u_guard (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .start_i(flush_req),
        .done_o(guard_done)
    );

    // Completion flags and the interrupt line
    event_flags #(
        .N(EV_NUM)
    ) u_flags (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .set_i(ev_set),
        .clr_i(ev_clr),
        .mask_i(q_r.mask),
        .flag_o(ev_flag),
        .irq_o(irq_o)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata_o = q_r.rdata;
    assign pready_o = q_r.rdy;
    assign pslverr_o = q_r.serr;
    assign mode_async_o = q_r.csr[CSR_MODE];    // RQ8
    assign rx_enable_bit_o = q_r.csr[CSR_RE];   // RQ9
    assign slave_role_o = q_r.csr[CSR_SLAVE];   // RQ10
    assign async_cfg_o = q_r.ucr;
    assign generic_cfg_o = q_r.gcr;
    assign rate_mantissa_o = q_r.baud;
    assign tx_data_o = q_r.txbuf;
    assign tx_load_o = q_r.load;
    assign flush_o = q_r.flush;
    assign rx_done_irq_flag_o = ev_flag[EV_RX];
    assign tx_done_irq_flag_o = ev_flag[EV_TX];
    assign rx_done_dma_trigger_o = q_r.dma_rx;
    assign tx_done_dma_trigger_o = q_r.dma_tx;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_flush_idle;
        @(posedge mclk_i) disable iff (rst_i)
        flush_req |=> !active && flush_o && tx_data_o == 8'h00 ##1 !active;
    endproperty
    a_flush_idle: assert property (p_flush_idle) // RQ1
        else $error("flush did not idle the unit");

    property p_flush_keeps;
        @(posedge mclk_i) disable iff (rst_i)
        (flush_req && !rx_frame_err_i && !rx_parity_err_i && !tx_done_i)
        |=> $stable(q_r.csr[CSR_FE:CSR_TXB]);
    endproperty
    a_flush_keeps: assert property (p_flush_keeps) // RQ19
        else $error("flush changed a status flag");

    property p_irq_gate;
        @(posedge mclk_i) disable iff (rst_i)
        irq_o == |(ev_flag & $past(q_r.mask));
    endproperty
    a_irq_gate: assert property (p_irq_gate) // RQ4
        else $error("interrupt does not follow enabled flags");

    property p_dma_pair;
        @(posedge mclk_i) disable iff (rst_i)
        (rx_done_dma_trigger_o |-> rx_done_irq_flag_o)
        and (tx_done_dma_trigger_o |-> tx_done_irq_flag_o) and !(rx_done_dma_trigger_o
        && $past(rx_done_dma_trigger_o) && !$past(rx_evt, 2));
    endproperty
    a_dma_pair: assert property (p_dma_pair) // RQ5
        else $error("DMA trigger without its event flag");

    property p_rx_done;
        @(posedge mclk_i) disable iff (rst_i)
        rx_evt |=> q_r.csr[CSR_RXB] && rx_done_dma_trigger_o && rx_done_irq_flag_o;
    endproperty
    a_rx_done: assert property (p_rx_done) // RQ12
        else $error("receive completion not reported");

    property p_rx_gated;
        @(posedge mclk_i) disable iff (rst_i)
        (rx_byte_i && mode_async_o && !rx_enable_bit_o) |=> !rx_done_dma_trigger_o;
    endproperty
    a_rx_gated: assert property (p_rx_gated) // RQ9
        else $error("receive event with receiver disabled");

    property p_errors;
        @(posedge mclk_i) disable iff (rst_i)
        ((rx_frame_err_i && rx_ok) |=> q_r.csr[CSR_FE])
        and ((rx_parity_err_i && rx_ok) |=> q_r.csr[CSR_ERR]);
    endproperty
    a_errors: assert property (p_errors) // RQ13
        else $error("error flag not set");

    property p_busy_rise;
        @(posedge mclk_i) disable iff (rst_i)
        $rose(active) |-> $past(xfer_start_i) && !$past(flush_req);
    endproperty
    a_busy_rise: assert property (p_busy_rise) // RQ16
        else $error("busy rose without a transfer start");

    property p_master_end;
        @(posedge mclk_i) disable iff (rst_i)
        (active && xfer_end_i && !flush_req && !mode_async_o && !slave_role_o)
        |=> !active && q_r.csr[CSR_TXB];
    endproperty
    a_master_end: assert property (p_master_end) // RQ18
        else $error("master transfer end not reported");

    property p_tx_done;
        @(posedge mclk_i) disable iff (rst_i)
        tx_evt |=> q_r.csr[CSR_TXB] ##1 tx_done_irq_flag_o || $past(ev_clr[EV_TX]);
    endproperty
    a_tx_done: assert property (p_tx_done) // RQ15
        else $error("transmit completion not reported");

endmodule : usart_status_flush_events

// ==== verif/core_model.sv ====
/*
 * Serial core stand-in: each buffer load taken while idle and not flushed becomes start, end and done pulses.
 * Assumes tx_load is a one-cycle pulse and flush is held while aborting.
 */
module core_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // From the control block
    input wire logic tx_load_i,
    input wire logic flush_i,
    input wire logic [5:0] lat_i,
    // Events back to it
    output logic xfer_start_o,
    output logic xfer_end_o,
    output logic tx_done_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [5:0] cnt_r;
    logic run_r;

    // Start at once, finish lat_i + 1 cycles later; a flush drops the transfer
    always_ff @(posedge mclk_i) begin
        xfer_start_o <= !rst_i && !flush_i && tx_load_i && !run_r;
        xfer_end_o <= !rst_i && !flush_i && run_r && cnt_r == 6'h00;
        tx_done_o <= !rst_i && !flush_i && run_r && cnt_r == 6'h00;
        if (rst_i || flush_i) begin
            run_r <= 1'b0;
            cnt_r <= 6'h00;
        end else if (tx_load_i && !run_r) begin
            run_r <= 1'b1;
            cnt_r <= lat_i;
        end else if (run_r && cnt_r == 6'h00) begin
            run_r <= 1'b0;
        end else if (run_r) begin
            cnt_r <= cnt_r - 6'h01;
        end
    end
endmodule : core_model

// ==== verif/tb.sv ====
/*
 * Self-checking bench of the serial control/status block and its core model.
 * Assumes usart_pkg is compiled first; each register sits in bits 7:0.
 */
module tb
    import usart_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [7:0] paddr_i, rx_data_i, generic_cfg_o, rate_mantissa_o, tx_data_o;
    logic [31:0] pwdata_i, prdata_o, rnd, q;
    logic xfer_start_i, xfer_end_i, rx_byte_i, rx_frame_err_i, rx_parity_err_i, tx_done_i;
    logic mode_async_o, rx_enable_bit_o, slave_role_o, tx_load_o, flush_o, irq_o, e;
    logic rx_done_irq_flag_o, tx_done_irq_flag_o, rx_done_dma_trigger_o, tx_done_dma_trigger_o;
    logic [6:0] async_cfg_o;
    logic [5:0] lat;
    int bad_count, n_tests;
    logic [7:0] offs [7] = '{OFF_CSR, OFF_UCR, OFF_GCR, OFF_BAUD, OFF_ISTAT, OFF_IMASK, OFF_DBUF};
    logic [7:0] rstv [7] = '{{CSR_RST, 1'b0}, {1'b0, UCR_RST}, GCR_RST, BAUD_RST, 8'h00,
        {6'h00, MASK_RST}, 8'h00};

    // Design with a short flush hold, and the core model beside it
    usart_status_flush_events #(.GUARD_CYCLES(4)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .xfer_start_i(xfer_start_i), .xfer_end_i(xfer_end_i),
        .rx_byte_i(rx_byte_i), .rx_data_i(rx_data_i), .rx_frame_err_i(rx_frame_err_i),
        .rx_parity_err_i(rx_parity_err_i), .tx_done_i(tx_done_i),
        .mode_async_o(mode_async_o), .rx_enable_bit_o(rx_enable_bit_o),
        .slave_role_o(slave_role_o), .async_cfg_o(async_cfg_o),
        .generic_cfg_o(generic_cfg_o), .rate_mantissa_o(rate_mantissa_o),
        .tx_data_o(tx_data_o), .tx_load_o(tx_load_o), .flush_o(flush_o),
        .rx_done_irq_flag_o(rx_done_irq_flag_o), .tx_done_irq_flag_o(tx_done_irq_flag_o),
        .rx_done_dma_trigger_o(rx_done_dma_trigger_o),
        .tx_done_dma_trigger_o(tx_done_dma_trigger_o), .irq_o(irq_o));
    core_model partner (.mclk_i(mclk_i), .rst_i(rst_i), .tx_load_i(tx_load_o),
        .flush_i(flush_o), .lat_i(lat), .xfer_start_o(xfer_start_i),
        .xfer_end_o(xfer_end_i), .tx_done_o(tx_done_i));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [31:0] bytes(input logic [31:0] w);
        return {24'h000000, w[7:0]};
    endfunction : bytes

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; holds the request until pready is seen high or 50 cycles have passed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1) begin
            bad_count++;
            $display("BAD %0t no pready", $time);
        end
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        #1;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h00000000);
        chk(q, x);
    endtask : rd

    // Core event pulse of one cycle: {parity, frame, byte}
    task automatic rx_ev(input logic [2:0] k, input logic [7:0] d);
        @(posedge mclk_i);
        {rx_parity_err_i, rx_frame_err_i, rx_byte_i} <= k;
        rx_data_i <= d;
        @(posedge mclk_i);
        {rx_parity_err_i, rx_frame_err_i, rx_byte_i} <= 3'b000;
        #1;
    endtask : rx_ev

    task automatic send(input logic [31:0] d);
        wr(OFF_DBUF, d);
        chk({24'h000000, tx_data_o}, bytes(d));
        chk({31'h0, tx_load_o}, 32'h1);
    endtask : send

    task automatic wait_tx();
        int n;
        n = 0;
        while (tx_done_dma_trigger_o !== 1'b1 && n < 100) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk({31'h0, tx_done_irq_flag_o}, 32'h1);
    endtask : wait_tx

    task automatic test_done();
        if (bad_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    initial begin
        #(5000 * 100);
        bad_count++;
        test_done();
    end

    initial begin
        {rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {4'h8, 40'h0};
        {rx_byte_i, rx_frame_err_i, rx_parity_err_i, rx_data_i} = 11'h000;
        lat = 6'h03;
        rnd = 32'h0B4F38A0;
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) rd(offs[i], {24'h000000, rstv[i]});
        rd(8'h1C, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Random values, sample phase bit kept clear
        repeat (4) begin
            rnd = lfsr(rnd);
            wr(OFF_GCR, rnd & 32'hFFFFFFBF);
            rd(OFF_GCR, bytes(rnd & 32'hFFFFFFBF));
            chk({24'h000000, generic_cfg_o}, bytes(rnd & 32'hFFFFFFBF));
            wr(OFF_BAUD, rnd);
            chk({24'h000000, rate_mantissa_o}, bytes(rnd));
        end
        for (int i = 0; i < 8; i++) begin
            wr(OFF_CSR, {24'h0, i[2:0], 5'h00});
            chk({29'h0, mode_async_o, rx_enable_bit_o, slave_role_o}, 32'(i));
            rd(OFF_CSR, {24'h0, i[2:0], 5'h00});
        end
        // Receive with enable, then errors, clear, and receive refused
        wr(OFF_CSR, 32'hC0);
        wr(OFF_IMASK, 32'h1);
        rnd = lfsr(rnd);
        rx_ev(3'b001, rnd[7:0]);
        chk({28'h0, rx_done_dma_trigger_o, tx_done_dma_trigger_o, rx_done_irq_flag_o, irq_o},
            32'hB);
        rd(OFF_ISTAT, 32'h1);
        rd(OFF_DBUF, bytes(rnd));
        rd(OFF_CSR, 32'hC4);
        rx_ev(3'b010, 8'h00);
        rd(OFF_CSR, 32'hD4);
        rx_ev(3'b100, 8'h00);
        rd(OFF_CSR, 32'hDC);
        wr(OFF_ISTAT, 32'h1);
        chk({30'h0, rx_done_irq_flag_o, irq_o}, 32'h0);
        wr(OFF_CSR, 32'h80);
        rx_ev(3'b001, 8'h5A);
        chk({30'h0, rx_done_dma_trigger_o, rx_done_irq_flag_o}, 32'h0);
        rd(OFF_CSR, 32'h80);
        // Transmit with its interrupt masked, then unmasked and cleared
        send(lfsr(rnd));
        wait_tx();
        chk({31'h0, irq_o}, 32'h0);
        wr(OFF_IMASK, 32'h3);
        // The interrupt follows the registered enables one cycle later
        @(posedge mclk_i);
        #1;
        chk({31'h0, irq_o}, 32'h1);
        rd(OFF_CSR, 32'h82);
        wr(OFF_ISTAT, 32'h2);
        chk({31'h0, irq_o}, 32'h0);
        // Synchronous master transfer with a slow core
        wr(OFF_CSR, 32'h00);
        lat = 6'h1F;
        send(rnd);
        rd(OFF_CSR, 32'h01);
        wait_tx();
        rd(OFF_CSR, 32'h02);
        wr(OFF_ISTAT, 32'h2);
        // Flush in mid-transfer
        rx_ev(3'b001, 8'hA5);
        send(rnd);
        rd(OFF_CSR, 32'h05);
        wr(OFF_UCR, 32'h82);
        chk({25'h0, async_cfg_o}, 32'h02);
        @(posedge mclk_i);
        #1;
        chk({31'h0, flush_o}, 32'h1);
        for (int n = 0; n < 20 && flush_o !== 1'b0; n++) @(posedge mclk_i);
        chk({31'h0, flush_o}, 32'h0);
        rd(OFF_CSR, 32'h04);
        rd(OFF_DBUF, 32'h0);
        chk({24'h0, tx_data_o}, 32'h0);
        rd(OFF_UCR, 32'h02);
        chk({31'h0, tx_done_irq_flag_o}, 32'h0);
        test_done();
    end
endmodule : tb
